/* File: verilog/isad_decoder.v */
// instruction decoder: format, fields, class, targets, register operands
// assumes: fetch presents one word with its pc per valid cycle; the
// execution pipeline supplies write-back and multiply/divide results
`timescale 1ns/100ps
`default_nettype none
`include "isad_defines.vh"

module isad_decoder (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // fetch side
  input wire instr_valid_in,
  input wire [31:0] instr_in,
  input wire [31:0] pc_in,
  // external branch condition pins
  input wire [`ISAD_NCOND-1:0] branch_condition_inputs_in,
  // register write-back and multiply/divide results
  input wire wb_en_in,
  input wire [4:0] wb_addr_in,
  input wire [31:0] wb_data_in,
  input wire md_wr_en_in,
  input wire [31:0] md_hi_in,
  input wire [31:0] md_lo_in,
  // format and class
  output reg dec_valid_out,
  output reg fmt_r_out,
  output reg fmt_i_out,
  output reg fmt_j_out,
  output reg cls_load_store_out,
  output reg cls_compute_out,
  output reg cls_jump_branch_out,
  output reg cls_coproc_out,
  output reg cls_special_out,
  output reg illegal_out,
  // raw fields
  output reg [5:0] opcode_out,
  output reg [4:0] rs_out,
  output reg [4:0] rt_out,
  output reg [4:0] rd_out,
  output reg [4:0] shamt_out,
  output reg [5:0] funct_out,
  output reg [15:0] imm_out,
  output reg [25:0] jtarget_out,
  // operands and destination
  output reg [31:0] imm_ext_out,
  output wire [31:0] rs_data_out,
  output wire [31:0] rt_data_out,
  output reg dest_en_out,
  output reg [4:0] dest_reg_out,
  output reg [31:0] link_addr_out,
  // memory access
  output reg is_load_out,
  output reg is_store_out,
  output wire [31:0] mem_addr_out,
  // control flow
  output reg is_jump_out,
  output reg is_branch_out,
  output wire [31:0] target_out,
  output wire taken_out,
  // coprocessor and multiply/divide
  output reg [1:0] cop_num_out,
  output reg [25:0] cop_word_out,
  output reg muldiv_out,
  output reg move_from_high_result_out,
  output reg move_from_low_result_out,
  output reg [31:0] hi_out,
  output reg [31:0] lo_out
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function [31:0] isad_sext16;
    input [15:0] v;
    begin
      isad_sext16 = {{16{v[15]}}, v};
    end
  endfunction

  // ----------------------------------------------------------------------
  // field split
  // ----------------------------------------------------------------------
  wire [5:0] op = instr_in[`ISAD_OP_HI:`ISAD_OP_LO];
  wire [4:0] rs = instr_in[`ISAD_RS_HI:`ISAD_RS_LO];
  wire [4:0] rt = instr_in[`ISAD_RT_HI:`ISAD_RT_LO];
  wire [4:0] rd = instr_in[`ISAD_RD_HI:`ISAD_RD_LO];
  wire [4:0] sh = instr_in[`ISAD_SH_HI:`ISAD_SH_LO];
  wire [5:0] fn = instr_in[`ISAD_FN_HI:`ISAD_FN_LO];
  wire [15:0] imm = instr_in[`ISAD_IMM_HI:0];
  wire [25:0] jt = instr_in[`ISAD_JT_HI:0];

  // ----------------------------------------------------------------------
  // condition pin synchroniser
  // ----------------------------------------------------------------------
  reg [`ISAD_NCOND-1:0] cond_meta_reg;
  reg [`ISAD_NCOND-1:0] cond_sync_reg;

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cond_meta_reg <= {`ISAD_NCOND{1'b0}};
      cond_sync_reg <= {`ISAD_NCOND{1'b0}};
    end else begin
      cond_meta_reg <= branch_condition_inputs_in;
      cond_sync_reg <= cond_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------------
  reg fr_n, fi_n, fj_n, ls_n, cmp_n, jb_n, cop_n, spc_n, ill_n;
  reg ld_n, st_n, jmp_n, br_n, jreg_n, dst_en_n, md_n;
  reg mfh_n, mfl_n, mth_n, mtl_n;
  reg [4:0] dst_n;
  reg [2:0] bc_n;
  reg [31:0] immx_n;
  reg [31:0] tgt_n;

  always @* begin
    fr_n = 1'b0;
    fi_n = 1'b0;
    fj_n = 1'b0;
    ls_n = 1'b0;
    cmp_n = 1'b0;
    jb_n = 1'b0;
    cop_n = 1'b0;
    spc_n = 1'b0;
    ill_n = 1'b0;
    ld_n = 1'b0;
    st_n = 1'b0;
    jmp_n = 1'b0;
    br_n = 1'b0;
    jreg_n = 1'b0;
    dst_en_n = 1'b0;
    md_n = 1'b0;
    mfh_n = 1'b0;
    mfl_n = 1'b0;
    mth_n = 1'b0;
    mtl_n = 1'b0;
    dst_n = `ISAD_ZERO_REG;
    bc_n = `ISAD_BC_EQ;
    immx_n = isad_sext16(imm);
    tgt_n = pc_in + `ISAD_PC_STEP + {immx_n[29:0], 2'b00};
    case (op)
      `ISAD_OP_SPECIAL: begin
        fr_n = 1'b1;
        case (fn)
          `ISAD_FN_SLL, `ISAD_FN_SRL, `ISAD_FN_SRA,
          `ISAD_FN_SLLV, `ISAD_FN_SRLV, `ISAD_FN_SRAV,
          `ISAD_FN_SLT, `ISAD_FN_SLTU: begin
            cmp_n = 1'b1;
            dst_en_n = 1'b1;
            dst_n = rd;
          end
          `ISAD_FN_JREG: begin
            jb_n = 1'b1;
            jmp_n = 1'b1;
            jreg_n = 1'b1;
          end
          `ISAD_FN_JREGLNK: begin
            jb_n = 1'b1;
            jmp_n = 1'b1;
            jreg_n = 1'b1;
            dst_en_n = 1'b1;
            dst_n = `ISAD_LINK_REG;
          end
          `ISAD_FN_SYSCALL, `ISAD_FN_BREAK: begin
            spc_n = 1'b1;
          end
          `ISAD_FN_MFHIGH, `ISAD_FN_MFLOW: begin
            spc_n = 1'b1;
            mfh_n = (fn == `ISAD_FN_MFHIGH);
            mfl_n = (fn == `ISAD_FN_MFLOW);
            dst_en_n = 1'b1;
            dst_n = rd;
          end
          `ISAD_FN_MTHIGH, `ISAD_FN_MTLOW: begin
            spc_n = 1'b1;
            mth_n = (fn == `ISAD_FN_MTHIGH);
            mtl_n = (fn == `ISAD_FN_MTLOW);
          end
          default: begin
            if ((fn >= `ISAD_FN_MULT) && (fn <= `ISAD_FN_DIVU)) begin
              cmp_n = 1'b1;
              md_n = 1'b1;
            end else if ((fn >= `ISAD_FN_ADD) && (fn <= `ISAD_FN_NOR)) begin
              cmp_n = 1'b1;
              dst_en_n = 1'b1;
              dst_n = rd;
            end else begin
              ill_n = 1'b1;
            end
          end
        endcase
      end
      `ISAD_OP_REGIMM: begin
        fi_n = 1'b1;
        jb_n = 1'b1;
        br_n = 1'b1;
        bc_n = rt[0] ? `ISAD_BC_GEZ : `ISAD_BC_LTZ;
        case (rt)
          `ISAD_RT_BLTZ, `ISAD_RT_BGEZ: begin
            dst_en_n = 1'b0;
          end
          `ISAD_RT_BLTZLNK, `ISAD_RT_BGEZLNK: begin
            dst_en_n = 1'b1;
            dst_n = `ISAD_LINK_REG;
          end
          default: begin
            ill_n = 1'b1;
            br_n = 1'b0;
          end
        endcase
      end
      `ISAD_OP_J, `ISAD_OP_JAL: begin
        fj_n = 1'b1;
        jb_n = 1'b1;
        jmp_n = 1'b1;
        tgt_n = {pc_in[31:28], jt, 2'b00};
        dst_en_n = (op == `ISAD_OP_JAL);
        dst_n = (op == `ISAD_OP_JAL) ? `ISAD_LINK_REG : `ISAD_ZERO_REG;
      end
      `ISAD_OP_BEQ, `ISAD_OP_BNE, `ISAD_OP_BLEZ, `ISAD_OP_BGTZ: begin
        fi_n = 1'b1;
        jb_n = 1'b1;
        br_n = 1'b1;
        bc_n = {1'b0, op[1:0]};
      end
      `ISAD_OP_ANDI, `ISAD_OP_ORI, `ISAD_OP_XORI: begin
        fi_n = 1'b1;
        cmp_n = 1'b1;
        dst_en_n = 1'b1;
        dst_n = rt;
        immx_n = {16'h0000, imm};
      end
      `ISAD_OP_LDUPPER: begin
        fi_n = 1'b1;
        cmp_n = 1'b1;
        dst_en_n = 1'b1;
        dst_n = rt;
        immx_n = {imm, 16'h0000};
      end
      `ISAD_OP_SB, `ISAD_OP_SH, `ISAD_OP_SWL, `ISAD_OP_SW,
      `ISAD_OP_SWRIGHT: begin
        fi_n = 1'b1;
        ls_n = 1'b1;
        st_n = 1'b1;
      end
      default: begin
        if ((op >= `ISAD_OP_ADDI) && (op <= `ISAD_OP_XORI)) begin
          fi_n = 1'b1;
          cmp_n = 1'b1;
          dst_en_n = 1'b1;
          dst_n = rt;
        end else if ((op >= `ISAD_OP_LB) && (op <= `ISAD_OP_LWR)) begin
          fi_n = 1'b1;
          ls_n = 1'b1;
          ld_n = 1'b1;
          dst_en_n = 1'b1;
          dst_n = rt;
        end else if ((op >= `ISAD_OP_LWC0) && (op <= `ISAD_OP_LWC3)) begin
          fi_n = 1'b1;
          ls_n = 1'b1;
          cop_n = 1'b1;
          ld_n = 1'b1;
        end else if ((op >= `ISAD_OP_SWC0) && (op <= `ISAD_OP_SWC3)) begin
          fi_n = 1'b1;
          ls_n = 1'b1;
          cop_n = 1'b1;
          st_n = 1'b1;
        end else if ((op >= `ISAD_OP_COP0) && (op <= `ISAD_OP_COP3)) begin
          cop_n = 1'b1;
          if (rs == `ISAD_RS_COPBR) begin
            fi_n = 1'b1;
            jb_n = 1'b1;
            br_n = 1'b1;
            bc_n = rt[0] ? `ISAD_BC_CPT : `ISAD_BC_CPF;
          end else begin
            fr_n = 1'b1;
          end
        end else begin
          fr_n = 1'b1;
          ill_n = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // decode stage registers, aligned with register file read data
  // ----------------------------------------------------------------------
  reg jreg_reg;
  reg [2:0] bc_reg;
  reg [31:0] tgt_reg;
  reg cond_reg;
  reg mth_reg;
  reg mtl_reg;

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dec_valid_out <= 1'b0;
      {fmt_r_out, fmt_i_out, fmt_j_out} <= 3'h0;
      {cls_load_store_out, cls_compute_out, cls_jump_branch_out} <= 3'h0;
      {cls_coproc_out, cls_special_out, illegal_out} <= 3'h0;
      {is_load_out, is_store_out, is_jump_out, is_branch_out} <= 4'h0;
      {muldiv_out, move_from_high_result_out, move_from_low_result_out} <= 3'h0;
      {jreg_reg, mth_reg, mtl_reg, cond_reg, dest_en_out} <= 5'h00;
      opcode_out <= 6'h00;
      funct_out <= 6'h00;
      {rs_out, rt_out, rd_out, shamt_out, dest_reg_out} <= 25'h000_0000;
      imm_out <= 16'h0000;
      jtarget_out <= 26'h000_0000;
      cop_word_out <= 26'h000_0000;
      cop_num_out <= 2'h0;
      bc_reg <= `ISAD_BC_EQ;
      imm_ext_out <= `ISAD_WORD_RST;
      tgt_reg <= `ISAD_WORD_RST;
      link_addr_out <= `ISAD_WORD_RST;
    end else begin
      dec_valid_out <= instr_valid_in;
      if (instr_valid_in) begin
        {fmt_r_out, fmt_i_out, fmt_j_out} <= {fr_n, fi_n, fj_n};
        {cls_load_store_out, cls_compute_out, cls_jump_branch_out} <= {ls_n, cmp_n, jb_n};
        {cls_coproc_out, cls_special_out, illegal_out} <= {cop_n, spc_n, ill_n};
        {is_load_out, is_store_out, is_jump_out, is_branch_out} <= {ld_n, st_n, jmp_n, br_n};
        {muldiv_out, move_from_high_result_out, move_from_low_result_out} <= {md_n, mfh_n, mfl_n};
        {jreg_reg, mth_reg, mtl_reg, dest_en_out} <= {jreg_n, mth_n, mtl_n, dst_en_n};
        cond_reg <= cond_sync_reg[op[1:0]];
        opcode_out <= op;
        funct_out <= fn;
        {rs_out, rt_out, rd_out, shamt_out, dest_reg_out} <= {rs, rt, rd, sh, dst_n};
        imm_out <= imm;
        jtarget_out <= jt;
        cop_word_out <= jt;
        cop_num_out <= op[1:0];
        bc_reg <= bc_n;
        imm_ext_out <= immx_n;
        tgt_reg <= tgt_n;
        link_addr_out <= pc_in + `ISAD_LINK_STEP;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register file, high/low result registers
  // ----------------------------------------------------------------------
  isad_regfile #(
    .AW(5),
    .DW(32)
  ) i_isad_regfile (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .rd_en_in(instr_valid_in),
    .rd_a_addr_in(rs),
    .rd_b_addr_in(rt),
    .rd_a_data_out(rs_data_out),
    .rd_b_data_out(rt_data_out),
    .wr_en_in(wb_en_in),
    .wr_addr_in(wb_addr_in),
    .wr_data_in(wb_data_in)
  );

  // an explicit move-to in the same cycle overrides the unit's result
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      hi_out <= `ISAD_WORD_RST;
      lo_out <= `ISAD_WORD_RST;
    end else begin
      if (md_wr_en_in) begin
        hi_out <= md_hi_in;
        lo_out <= md_lo_in;
      end
      if (dec_valid_out && mth_reg) begin
        hi_out <= rs_data_out;
      end
      if (dec_valid_out && mtl_reg) begin
        lo_out <= rs_data_out;
      end
    end
  end

  // ----------------------------------------------------------------------
  // targets, branch outcome and effective address
  // ----------------------------------------------------------------------
  reg cond_true;

  always @* begin
    case (bc_reg)
      `ISAD_BC_EQ: cond_true = (rs_data_out == rt_data_out);
      `ISAD_BC_NE: cond_true = (rs_data_out != rt_data_out);
      `ISAD_BC_LEZ: cond_true = rs_data_out[31] | (rs_data_out == `ISAD_WORD_RST);
      `ISAD_BC_GTZ: cond_true = ~rs_data_out[31] & (rs_data_out != `ISAD_WORD_RST);
      `ISAD_BC_LTZ: cond_true = rs_data_out[31];
      `ISAD_BC_GEZ: cond_true = ~rs_data_out[31];
      `ISAD_BC_CPT: cond_true = cond_reg;
      `ISAD_BC_CPF: cond_true = ~cond_reg;
      default: cond_true = 1'b0;
    endcase
  end

  assign taken_out = dec_valid_out & (is_jump_out | (is_branch_out & cond_true));
  assign target_out = jreg_reg ? rs_data_out : tgt_reg;
  assign mem_addr_out = rs_data_out + imm_ext_out;

endmodule // isad_decoder

`default_nettype wire

/* File: verilog/isad_defines.vh */
// instruction decoder constants: field positions, opcodes, function codes,
// branch condition codes and reset values
// assumes: 32-bit fixed-length instruction words, byte-addressed word-aligned fetch
`ifndef ISAD_DEFINES_VH
`define ISAD_DEFINES_VH

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ISAD_OP_HI 31
`define ISAD_OP_LO 26
`define ISAD_RS_HI 25
`define ISAD_RS_LO 21
`define ISAD_RT_HI 20
`define ISAD_RT_LO 16
`define ISAD_RD_HI 15
`define ISAD_RD_LO 11
`define ISAD_SH_HI 10
`define ISAD_SH_LO 6
`define ISAD_FN_HI 5
`define ISAD_FN_LO 0
`define ISAD_IMM_HI 15
`define ISAD_JT_HI 25

// ----------------------------------------------------------------------
// primary opcodes
// ----------------------------------------------------------------------
`define ISAD_OP_SPECIAL 6'h00
`define ISAD_OP_REGIMM 6'h01
`define ISAD_OP_J 6'h02
`define ISAD_OP_JAL 6'h03
`define ISAD_OP_BEQ 6'h04
`define ISAD_OP_BNE 6'h05
`define ISAD_OP_BLEZ 6'h06
`define ISAD_OP_BGTZ 6'h07
`define ISAD_OP_ADDI 6'h08
`define ISAD_OP_ADDIU 6'h09
`define ISAD_OP_SLTI 6'h0A
`define ISAD_OP_SLTIU 6'h0B
`define ISAD_OP_ANDI 6'h0C
`define ISAD_OP_ORI 6'h0D
`define ISAD_OP_XORI 6'h0E
`define ISAD_OP_LDUPPER 6'h0F
`define ISAD_OP_COP0 6'h10
`define ISAD_OP_COP3 6'h13
`define ISAD_OP_LB 6'h20
`define ISAD_OP_LWR 6'h26
`define ISAD_OP_SB 6'h28
`define ISAD_OP_SH 6'h29
`define ISAD_OP_SWL 6'h2A
`define ISAD_OP_SW 6'h2B
`define ISAD_OP_SWRIGHT 6'h2E
`define ISAD_OP_LWC0 6'h30
`define ISAD_OP_LWC3 6'h33
`define ISAD_OP_SWC0 6'h38
`define ISAD_OP_SWC3 6'h3B

// ----------------------------------------------------------------------
// function codes of the register-type group
// ----------------------------------------------------------------------
`define ISAD_FN_SLL 6'h00
`define ISAD_FN_SRL 6'h02
`define ISAD_FN_SRA 6'h03
`define ISAD_FN_SLLV 6'h04
`define ISAD_FN_SRLV 6'h06
`define ISAD_FN_SRAV 6'h07
`define ISAD_FN_JREG 6'h08
`define ISAD_FN_JREGLNK 6'h09
`define ISAD_FN_SYSCALL 6'h0C
`define ISAD_FN_BREAK 6'h0D
`define ISAD_FN_MFHIGH 6'h10
`define ISAD_FN_MTHIGH 6'h11
`define ISAD_FN_MFLOW 6'h12
`define ISAD_FN_MTLOW 6'h13
`define ISAD_FN_MULT 6'h18
`define ISAD_FN_DIVU 6'h1B
`define ISAD_FN_ADD 6'h20
`define ISAD_FN_NOR 6'h27
`define ISAD_FN_SLT 6'h2A
`define ISAD_FN_SLTU 6'h2B

// ----------------------------------------------------------------------
// rt codes of the regimm group, coprocessor branch selector
// ----------------------------------------------------------------------
`define ISAD_RT_BLTZ 5'h00
`define ISAD_RT_BGEZ 5'h01
`define ISAD_RT_BLTZLNK 5'h10
`define ISAD_RT_BGEZLNK 5'h11
`define ISAD_RS_COPBR 5'h08

// ----------------------------------------------------------------------
// branch condition codes, link register, constants
// ----------------------------------------------------------------------
`define ISAD_BC_EQ 3'h0
`define ISAD_BC_NE 3'h1
`define ISAD_BC_LEZ 3'h2
`define ISAD_BC_GTZ 3'h3
`define ISAD_BC_LTZ 3'h4
`define ISAD_BC_GEZ 3'h5
`define ISAD_BC_CPT 3'h6
`define ISAD_BC_CPF 3'h7
`define ISAD_LINK_REG 5'h1F
`define ISAD_ZERO_REG 5'h00
`define ISAD_PC_STEP 32'h0000_0004
`define ISAD_LINK_STEP 32'h0000_0008
`define ISAD_WORD_RST 32'h0000_0000
`define ISAD_NCOND 4

`endif

/* File: verilog/isad_regfile.v */
// general register file: two read ports with registered data, one write port
// assumes: same clock as the decoder; register zero is never stored
`timescale 1ns/100ps
`default_nettype none
`include "isad_defines.vh"

module isad_regfile #(
  parameter AW = 5,
  parameter DW = 32
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // read ports
  input wire rd_en_in,
  input wire [AW-1:0] rd_a_addr_in,
  input wire [AW-1:0] rd_b_addr_in,
  output reg [DW-1:0] rd_a_data_out,
  output reg [DW-1:0] rd_b_data_out,
  // write port
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [DW-1:0] wr_data_in
);

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];

  // register zero reads zero; a same-cycle write is forwarded
  function [DW-1:0] isad_pick;
    input [AW-1:0] addr;
    begin
      if (addr == {AW{1'b0}}) begin
        isad_pick = {DW{1'b0}};
      end else if (wr_en_in && (wr_addr_in == addr)) begin
        isad_pick = wr_data_in;
      end else begin
        isad_pick = mem_reg[addr];
      end
    end
  endfunction

  always @(posedge clk_sys_in) begin
    if (wr_en_in && (wr_addr_in != {AW{1'b0}})) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rd_a_data_out <= {DW{1'b0}};
      rd_b_data_out <= {DW{1'b0}};
    end else if (rd_en_in) begin
      rd_a_data_out <= isad_pick(rd_a_addr_in);
      rd_b_data_out <= isad_pick(rd_b_addr_in);
    end
  end

endmodule // isad_regfile

`default_nettype wire

/* File: sim/isad_exec_model.sv */
// execution side model: register write-back and multiply/divide results
// assumes: shares the decoder clock; driven by bench tasks
`timescale 1ns/100ps
`default_nettype none
module isad_exec_model (
  // clock
  input wire logic clk_sys_in,
  // write-back
  output logic wb_en_out,
  output logic [4:0] wb_addr_out,
  output logic [31:0] wb_data_out,
  // multiply/divide results
  output logic md_wr_en_out,
  output logic [31:0] md_hi_out,
  output logic [31:0] md_lo_out
);
  initial begin
    wb_en_out = 1'b0;
    wb_addr_out = 5'h00;
    wb_data_out = 32'h0000_0000;
    md_wr_en_out = 1'b0;
    md_hi_out = 32'h0000_0000;
    md_lo_out = 32'h0000_0000;
  end
  // released lines show the inverse so stale data is not mistaken for live
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    wb_en_out <= 1'b1;
    wb_addr_out <= a;
    wb_data_out <= d;
    @(posedge clk_sys_in);
    wb_en_out <= 1'b0;
    wb_addr_out <= ~a;
    wb_data_out <= ~d;
  endtask
  task automatic md(input logic [31:0] h, input logic [31:0] l);
    @(posedge clk_sys_in);
    md_wr_en_out <= 1'b1;
    md_hi_out <= h;
    md_lo_out <= l;
    @(posedge clk_sys_in);
    md_wr_en_out <= 1'b0;
    md_hi_out <= ~h;
    md_lo_out <= ~l;
  endtask
endmodule // isad_exec_model
`default_nettype wire

/* File: sim/isad_checker.sv */
// decoder port checker, bound to the decoder
// assumes: single clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module isad_checker (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // fetch side
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] pc_in,
  // decode results
  input wire logic dec_valid_out,
  input wire logic fmt_r_out,
  input wire logic fmt_i_out,
  input wire logic fmt_j_out,
  input wire logic cls_special_out,
  input wire logic [5:0] opcode_out,
  input wire logic [4:0] rs_out,
  input wire logic [4:0] rt_out,
  input wire logic [15:0] imm_out,
  input wire logic is_load_out,
  input wire logic is_store_out,
  input wire logic [31:0] imm_ext_out,
  input wire logic [31:0] rs_data_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [31:0] target_out,
  input wire logic [31:0] link_addr_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  AST_DEC_ONE_CYCLE: assert property ($past(rst_n_in) |->
    dec_valid_out == $past(instr_valid_in))
    else $error("decode valid not one cycle after request");
  AST_FMT_ONEHOT: assert property (dec_valid_out |->
    $onehot({fmt_r_out, fmt_i_out, fmt_j_out}))
    else $error("format not one-hot");
  AST_FIELDS: assert property (instr_valid_in |=>
    {opcode_out, rs_out, rt_out, imm_out} == $past(instr_in))
    else $error("raw fields wrong");
  AST_JTARGET: assert property (dec_valid_out && fmt_j_out |->
    target_out == {$past(pc_in[31:28]), $past(instr_in[25:0]), 2'b00})
    else $error("jump target wrong");
  AST_MEMADDR: assert property (dec_valid_out && (is_load_out || is_store_out) |->
    fmt_i_out && mem_addr_out == rs_data_out + {{16{imm_out[15]}}, imm_out})
    else $error("memory address wrong");
  AST_LINK: assert property (dec_valid_out |->
    link_addr_out == $past(pc_in) + 32'h0000_0008)
    else $error("link address wrong");
  AST_SPECIAL: assert property (dec_valid_out && cls_special_out |-> fmt_r_out)
    else $error("special not register-type");
  AST_IDLE: assert property (!instr_valid_in |=>
    !dec_valid_out ##1 (dec_valid_out == $past(instr_valid_in)))
    else $error("decode valid without request");
endmodule // isad_checker
bind isad_decoder isad_checker i_isad_checker (.*);
`default_nettype wire

/* File: sim/tb_top.sv */
// decoder testbench: directed scenarios, self-checking
// assumes: decoder and exec model on one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "isad_defines.vh"
module tb_top;
  logic clk_sys_in, rst_n_in, instr_valid_in, wb_en_in, md_wr_en_in;
  logic [31:0] instr_in, pc_in, wb_data_in, md_hi_in, md_lo_in;
  logic [3:0] branch_condition_inputs_in;
  logic [4:0] wb_addr_in;
  logic dec_valid_out, fmt_r_out, fmt_i_out, fmt_j_out, cls_load_store_out, cls_compute_out;
  logic cls_jump_branch_out, cls_coproc_out, cls_special_out, illegal_out, dest_en_out;
  logic is_load_out, is_store_out, is_jump_out, is_branch_out, taken_out, muldiv_out;
  logic move_from_high_result_out, move_from_low_result_out;
  logic [5:0] opcode_out, funct_out;
  logic [4:0] rs_out, rt_out, rd_out, shamt_out, dest_reg_out;
  logic [15:0] imm_out;
  logic [25:0] jtarget_out, cop_word_out;
  logic [1:0] cop_num_out;
  logic [31:0] imm_ext_out, rs_data_out, rt_data_out, link_addr_out, mem_addr_out;
  logic [31:0] target_out, hi_out, lo_out;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [31:0] DN = 32'h8000_0010;
  isad_decoder i_isad_decoder (.*);
  isad_exec_model i_isad_exec_model (.clk_sys_in(clk_sys_in), .wb_en_out(wb_en_in),
    .wb_addr_out(wb_addr_in), .wb_data_out(wb_data_in), .md_wr_en_out(md_wr_en_in),
    .md_hi_out(md_hi_in), .md_lo_out(md_lo_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] iw(input logic [5:0] op, input logic [4:0] s,
                                     input logic [4:0] t, input logic [15:0] k);
    return {op, s, t, k};
  endfunction
  // one word in, results checked in the cycle after capture
  task automatic issue(input logic [31:0] w, input logic [31:0] p);
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b1;
    instr_in <= w;
    pc_in <= p;
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    i_isad_exec_model.wr(5'h05, DN);
    i_isad_exec_model.wr(5'h06, 32'h0000_0020);
    i_isad_exec_model.wr(5'h00, 32'hFFFF_FFFF);
    issue(iw(`ISAD_OP_SPECIAL, 5'h05, 5'h00, {5'h03, 5'h00, `ISAD_FN_ADD}), 32'h0000_0000);
    chk(rs_data_out, DN);
    chk(rt_data_out, 32'h0000_0000);
    chk({fmt_r_out, cls_compute_out, dest_en_out, dest_reg_out}, {3'b111, 5'h03});
    issue(iw(`ISAD_OP_SPECIAL, 5'h00, 5'h06, {5'h07, 5'h1F, `ISAD_FN_SLL}), 32'h0000_0000);
    chk({shamt_out, funct_out, rd_out}, {5'h1F, `ISAD_FN_SLL, 5'h07});
  endtask
  task automatic t_mem();
    issue(iw(`ISAD_OP_LB, 5'h05, 5'h02, 16'hFFFC), 32'h0000_0000);
    chk({is_load_out, fmt_i_out, cls_load_store_out, dest_reg_out}, {3'b111, 5'h02});
    chk(mem_addr_out, 32'h8000_000C);
    issue(iw(`ISAD_OP_SW, 5'h06, 5'h05, 16'h0008), 32'h0000_0000);
    chk({is_store_out, dest_en_out, mem_addr_out}, {2'b10, 32'h0000_0028});
  endtask
  task automatic t_imm();
    logic [31:0] e;
    for (int op = 8; op < 16; op++) begin
      issue(iw(op[5:0], 5'h05, 5'h09, 16'h8001), 32'h0000_0000);
      e = (op == 15) ? 32'h8001_0000 : (op >= 12) ? 32'h0000_8001 : 32'hFFFF_8001;
      chk({fmt_i_out, illegal_out, cls_compute_out, dest_reg_out}, {3'b101, 5'h09});
      chk(imm_ext_out, e);
    end
  endtask
  task automatic t_jump();
    issue({`ISAD_OP_JAL, 26'h123_4567}, 32'hA000_0010);
    chk(target_out, {4'hA, 26'h123_4567, 2'b00});
    chk({fmt_j_out, taken_out, dest_en_out, dest_reg_out}, {3'b111, 5'h1F});
    chk(link_addr_out, 32'hA000_0018);
    chk({is_jump_out, cls_jump_branch_out, jtarget_out}, {2'b11, 26'h123_4567});
    issue(iw(`ISAD_OP_SPECIAL, 5'h05, 5'h00, {5'h1F, 5'h00, `ISAD_FN_JREGLNK}), 32'h0000_0040);
    chk({target_out, fmt_r_out, taken_out, dest_reg_out}, {DN, 2'b11, 5'h1F});
  endtask
  task automatic t_branch();
    logic [4:0] rc [4] = '{`ISAD_RT_BLTZ, `ISAD_RT_BGEZ, `ISAD_RT_BLTZLNK, `ISAD_RT_BGEZLNK};
    issue(iw(`ISAD_OP_BEQ, 5'h05, 5'h05, 16'hFFFF), 32'h0000_0100);
    chk({target_out, taken_out, fmt_i_out}, {32'h0000_0100, 2'b11});
    issue(iw(`ISAD_OP_BNE, 5'h05, 5'h06, 16'h0004), 32'h0000_0100);
    chk({target_out, taken_out}, {32'h0000_0114, 1'b1});
    issue(iw(`ISAD_OP_BLEZ, 5'h06, 5'h00, 16'h0001), 32'h0000_0100);
    chk({is_branch_out, taken_out}, 2'b10);
    issue(iw(`ISAD_OP_BGTZ, 5'h06, 5'h00, 16'h0001), 32'h0000_0100);
    chk({is_branch_out, taken_out}, 2'b11);
    for (int i = 0; i < 4; i++) begin
      issue(iw(`ISAD_OP_REGIMM, 5'h05, rc[i], 16'h0002), 32'h0000_0100);
      chk({illegal_out, taken_out, dest_en_out}, {1'b0, ~rc[i][0], rc[i][4]});
    end
  endtask
  task automatic t_cop();
    issue(iw(`ISAD_OP_LWC0, 5'h05, 5'h02, 16'h0004), 32'h0000_0000);
    chk({fmt_i_out, cls_coproc_out}, 2'b11);
    issue({`ISAD_OP_COP3, 26'h200_0ABC}, 32'h0000_0000);
    chk({fmt_r_out, cop_num_out, cop_word_out}, {3'b111, 26'h200_0ABC});
    branch_condition_inputs_in <= 4'h2;
    repeat (3) @(posedge clk_sys_in);
    issue(iw(6'h11, `ISAD_RS_COPBR, 5'h01, 16'h0001), 32'h0000_0200);
    chk({target_out, taken_out}, {32'h0000_0208, 1'b1});
    issue(iw(6'h11, `ISAD_RS_COPBR, 5'h00, 16'h0001), 32'h0000_0200);
    chk(taken_out, 1'b0);
  endtask
  task automatic t_special();
    i_isad_exec_model.md(32'h1234_5678, 32'h9ABC_DEF0);
    #1;
    chk({hi_out, lo_out}, {32'h1234_5678, 32'h9ABC_DEF0});
    issue(iw(`ISAD_OP_SPECIAL, 5'h00, 5'h00, {10'h000, `ISAD_FN_SYSCALL}), 32'h0000_0000);
    chk({fmt_r_out, cls_special_out}, 2'b11);
    issue(32'hFC00_0000, 32'h0000_0000);
    chk({fmt_r_out, fmt_i_out, illegal_out}, 3'b101);
    issue(iw(`ISAD_OP_SPECIAL, 5'h06, 5'h00, {10'h000, `ISAD_FN_MTHIGH}), 32'h0000_0000);
    @(posedge clk_sys_in);
    #1;
    chk(hi_out, 32'h0000_0020);
  endtask
  initial begin
    rst_n_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = 32'h0000_0000;
    pc_in = 32'h0000_0000;
    branch_condition_inputs_in = 4'h0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_mem();
    t_imm();
    t_jump();
    t_branch();
    t_cop();
    t_special();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
